/* File: crs_core_register_set.sv */
// Purpose: architectural register set of an 8-bit core
// Assumes: inputs synchronous to clk; one op per cycle from the execution unit
// Notes:   stack bytes move through stackAddr/stackWrData/stackRdData, one per cycle
`timescale 1ns/10ps
`include "crs_consts.svh"
module crs_core_register_set
    import crs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire crs_cmd_t    cmd,
    input  wire logic [7:0]  stackRdData,
    output logic [7:0]       accOut,
    output logic [7:0]       idx1Out,
    output logic [7:0]       idx2Out,
    output logic [15:0]      pcOut,
    output logic [7:0]       flagsOut,
    output logic [15:0]      stackPtrOut,
    output logic [15:0]      stackAddr,
    output logic [7:0]       stackWrData,
    output logic             stackWrEn,
    output logic             irqBusy
);

    logic [7:0]  acc_reg;
    logic [7:0]  idx1_reg;
    logic [7:0]  idx2_reg;
    logic [15:0] pc_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  spLow_reg;
    logic [7:0]  spLow_next;
    logic [15:0] stackAddr_reg;
    logic [7:0]  stackWrData_reg;
    logic        stackWrEn_reg;
    logic [2:0]  frameCnt_reg;
    logic        framePush_reg;
    logic [1:0]  prioHold_reg;
    logic        frameActive;
    logic        doPush;
    logic        doPop;

    // wrap within the 128-byte window; bit 7 of the low byte stays at zero
    function automatic logic [7:0] spStep(input logic [7:0] sp, input logic up);
        logic [7:0] r;
        r = up ? (sp + 8'h01) : (sp - 8'h01);
        return r & `CRS_SP_LOW_MASK;
    endfunction

    // frame slot n maps to the register saved there
    function automatic crs_sel_t frameSel(input logic [2:0] n);
        crs_sel_t s;
        unique case (n)
            3'h0:    s = CRS_SEL_PCL;
            3'h1:    s = CRS_SEL_PCH;
            3'h2:    s = CRS_SEL_IDX1;
            3'h3:    s = CRS_SEL_ACC;
            default: s = CRS_SEL_FLAG;
        endcase
        return s;
    endfunction

    assign frameActive = (frameCnt_reg != 3'h0);
    // commands arriving mid-frame are dropped; the frame owns the stack port
    assign doPush = (!frameActive && cmd.op == CRS_OP_PUSH) || (frameActive && framePush_reg);
    assign doPop  = (!frameActive && cmd.op == CRS_OP_POP) || (frameActive && !framePush_reg);

    // selector for the byte a push writes
    function automatic logic [7:0] regByte(input crs_sel_t s, input logic [7:0] a,
                                           input logic [7:0] x, input logic [7:0] y,
                                           input logic [15:0] p, input logic [7:0] f);
        logic [7:0] b;
        unique case (s)
            CRS_SEL_PCL:  b = p[7:0];
            CRS_SEL_PCH:  b = p[15:8];
            CRS_SEL_IDX1: b = x;
            CRS_SEL_ACC:  b = a;
            CRS_SEL_FLAG: b = f;
            default:      b = y;
        endcase
        return b;
    endfunction

    // frame sequencer: 5 push or pop cycles per interrupt entry or return
    // requests that land mid-frame are dropped; callers wait five cycles
    // a new entry that lands before the running frame has ended is dropped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frameCnt_reg  <= 3'h0;
            framePush_reg <= 1'b0;
        end else if (!frameActive && cmd.op == CRS_OP_IRQENTER) begin
            frameCnt_reg  <= `CRS_IRQ_FRAME_LEN;
            framePush_reg <= 1'b1;
        end else if (!frameActive && cmd.op == CRS_OP_IRQRETURN) begin
            frameCnt_reg  <= `CRS_IRQ_FRAME_LEN;
            framePush_reg <= 1'b0;
        end else if (frameActive) begin
            frameCnt_reg <= frameCnt_reg - 3'h1;
        end
    end

    // one pointer move per cycle; a frame cycle always wins
    always_comb begin
        spLow_next = spLow_reg;
        if (doPush) begin
            spLow_next = spStep(spLow_reg, 1'b0);
        end else if (doPop) begin
            spLow_next = spStep(spLow_reg, 1'b1);
        end else if (cmd.op == CRS_OP_CALL) begin
            spLow_next = spStep(spStep(spLow_reg, 1'b0), 1'b0);
        end else if (cmd.op == CRS_OP_SPRESET) begin
            spLow_next = `CRS_SP_LOW_TOP;
        end else if (cmd.op == CRS_OP_SPLOAD) begin
            spLow_next = cmd.data & `CRS_SP_LOW_MASK;
        end
    end

    // reset lands on the top of the window
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            spLow_reg <= `CRS_SP_LOW_TOP;
        end else begin
            spLow_reg <= spLow_next;
        end
    end

    // stack port: push writes at the current pointer, pop reads one above
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stackAddr_reg   <= `CRS_SP_RESET;
            stackWrData_reg <= 8'h00;
            stackWrEn_reg   <= 1'b0;
        end else begin
            stackWrEn_reg <= doPush;
            if (doPush) begin
                stackAddr_reg <= {`CRS_SP_HIGH_BYTE, spLow_reg};
                stackWrData_reg <= regByte(frameActive ? frameSel(3'h5 - frameCnt_reg)
                                           : cmd.sel, acc_reg, idx1_reg, idx2_reg,
                                           pc_reg, flags_reg);
            end else if (doPop) begin
                stackAddr_reg <= {`CRS_SP_HIGH_BYTE, spStep(spLow_reg, 1'b1)};
            end
        end
    end

    // pop data lands combinationally from the stack memory this cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_reg <= `CRS_ACC_RESET;
        end else if (doPop && (frameActive ? frameCnt_reg == 3'h4
                                           : cmd.sel == CRS_SEL_ACC)) begin
            acc_reg <= stackRdData;
        end else if (!frameActive && cmd.writeAcc &&
                     (cmd.op == CRS_OP_ALU || cmd.op == CRS_OP_ADD)) begin
            acc_reg <= cmd.result;
        end
    end

    // first index only changes through pops, explicit or in a return frame
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idx1_reg <= 8'h00;
        end else if (doPop && (frameActive ? frameCnt_reg == 3'h3
                                           : cmd.sel == CRS_SEL_IDX1)) begin
            idx1_reg <= stackRdData;
        end
    end

    // second index is only reached by explicit pops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idx2_reg <= 8'h00;
        end else if (!frameActive && cmd.op == CRS_OP_POP && cmd.sel == CRS_SEL_IDX2) begin
            idx2_reg <= stackRdData;
        end
    end

    // a return frame refills the high byte first, then the low byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc_reg <= `CRS_PC_RESET;
        end else if (doPop && frameActive && frameCnt_reg == 3'h2) begin
            pc_reg[15:8] <= stackRdData;
        end else if (doPop && frameActive && frameCnt_reg == 3'h1) begin
            pc_reg[7:0] <= stackRdData;
        end else if (!frameActive && cmd.pcLoad) begin
            pc_reg <= cmd.pcValue;
        end
    end

    // level for the entry frame, held until the old flags are on the stack
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prioHold_reg <= 2'h0;
        end else if (!frameActive && cmd.op == CRS_OP_IRQENTER) begin
            prioHold_reg <= cmd.prio;
        end
    end

    // flag register; undefined bits 6 and 7 come out of reset as one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_reg <= `CRS_FLAGS_RESET;
        end else if (doPop && (frameActive ? frameCnt_reg == 3'h5
                                           : cmd.sel == CRS_SEL_FLAG)) begin
            flags_reg <= stackRdData;
        end else if (frameActive && framePush_reg && frameCnt_reg == 3'h1) begin
            // same edge as the flags push, so the stacked copy keeps the old level
            flags_reg[`CRS_FLAG_PRIO_HIGH] <= prioHold_reg[1];
            flags_reg[`CRS_FLAG_PRIO_LOW]  <= prioHold_reg[0];
        end else if (!frameActive) begin
            unique case (cmd.op)
                CRS_OP_ALU, CRS_OP_ADD: begin
                    flags_reg[`CRS_FLAG_NEG]   <= cmd.result[7];
                    flags_reg[`CRS_FLAG_ZERO]  <= (cmd.result == 8'h00);
                    flags_reg[`CRS_FLAG_CARRY] <= cmd.carry;
                    if (cmd.op == CRS_OP_ADD) begin
                        flags_reg[`CRS_FLAG_HALF] <= cmd.halfCarry;
                    end
                end
                CRS_OP_SETC: flags_reg[`CRS_FLAG_CARRY] <= 1'b1;
                CRS_OP_CLRC: flags_reg[`CRS_FLAG_CARRY] <= 1'b0;
                CRS_OP_PRIOSET: begin
                    flags_reg[`CRS_FLAG_PRIO_HIGH] <= cmd.prio[1];
                    flags_reg[`CRS_FLAG_PRIO_LOW]  <= cmd.prio[0];
                end
                CRS_OP_FLAGWRITE: flags_reg <= cmd.data;
                default: ;
            endcase
        end
    end

    // outputs straight from flip-flops; nothing here is memory mapped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            accOut      <= `CRS_ACC_RESET;
            idx1Out     <= 8'h00;
            idx2Out     <= 8'h00;
            pcOut       <= `CRS_PC_RESET;
            flagsOut    <= `CRS_FLAGS_RESET;
            stackPtrOut <= `CRS_SP_RESET;
            irqBusy     <= 1'b0;
        end else begin
            accOut      <= acc_reg;
            idx1Out     <= idx1_reg;
            idx2Out     <= idx2_reg;
            pcOut       <= pc_reg;
            flagsOut    <= flags_reg;
            stackPtrOut <= {`CRS_SP_HIGH_BYTE, spLow_reg};
            irqBusy     <= frameActive;
        end
    end

    // memory-side strobes are registered so the far side sees clean pulses
    assign stackAddr   = stackAddr_reg;
    assign stackWrData = stackWrData_reg;
    assign stackWrEn   = stackWrEn_reg;

    // checkers beside the logic; frame checks count from the edge that takes the entry or return command
    a_sp_upper_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        spLow_reg[7] == 1'b0) else $error("stack pointer left window");
    a_push_dec: assert property (@(posedge clk) disable iff (!rst_n)
        doPush |=> spLow_reg == spStep($past(spLow_reg), 1'b0)) else $error("push step");
    a_pop_inc: assert property (@(posedge clk) disable iff (!rst_n)
        (doPop && !doPush) |=> spLow_reg == spStep($past(spLow_reg), 1'b1))
        else $error("pop step");
    a_sp_reset_op: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd.op == CRS_OP_SPRESET && !frameActive) |=> spLow_reg == 8'h7F)
        else $error("stack reset");
    a_sp_load: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd.op == CRS_OP_SPLOAD && !frameActive) |=> spLow_reg == ($past(cmd.data) & 8'h7F))
        else $error("stack load");
    a_call_two: assert property (@(posedge clk) disable iff (!rst_n)
        (cmd.op == CRS_OP_CALL && !frameActive) |=>
        spLow_reg == spStep(spStep($past(spLow_reg), 1'b0), 1'b0)) else $error("call step");
    a_wr_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> stackWrEn == $past(doPush)) else $error("write strobe");

    a_frame_five: assert property (@(posedge clk) disable iff (!rst_n)
        (!frameActive && cmd.op == CRS_OP_IRQENTER) |=> frameActive [*5] ##1 !frameActive)
        else $error("frame length");
    a_busy_follows: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> irqBusy == $past(frameActive)) else $error("busy flag");
    a_frame_pcl_first: assert property (@(posedge clk) disable iff (!rst_n)
        (!frameActive && cmd.op == CRS_OP_IRQENTER) |=> ##1
        (stackWrEn && stackWrData == $past(pc_reg[7:0]) &&
         stackAddr[7:0] == $past(spLow_reg, 2))) else $error("pcl first");
    a_return_flags: assert property (@(posedge clk) disable iff (!rst_n)
        (!frameActive && cmd.op == CRS_OP_IRQRETURN) |=> ##1 flags_reg == $past(stackRdData))
        else $error("return pops flags first");
    a_idx2_kept: assert property (@(posedge clk) disable iff (!rst_n)
        frameActive |=> idx2_reg == $past(idx2_reg)) else $error("index2 changed");
    a_prio_load: assert property (@(posedge clk) disable iff (!rst_n)
        (!frameActive && cmd.op == CRS_OP_IRQENTER) |=> ##5
        {flags_reg[5], flags_reg[3]} == $past(cmd.prio, 6)) else $error("priority");

    a_acc_write: assert property (@(posedge clk) disable iff (!rst_n)
        (!frameActive && cmd.writeAcc && (cmd.op == CRS_OP_ALU || cmd.op == CRS_OP_ADD)) |=>
        acc_reg == $past(cmd.result)) else $error("accumulator write");
    a_pc_load: assert property (@(posedge clk) disable iff (!rst_n)
        (!frameActive && cmd.pcLoad) |=> pc_reg == $past(cmd.pcValue))
        else $error("program counter load");
    a_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (!frameActive && cmd.op == CRS_OP_ALU) |=>
        flags_reg[1] == ($past(cmd.result) == 8'h00) && flags_reg[2] == $past(cmd.result[7]))
        else $error("zero or negative flag");
    a_alu_carry: assert property (@(posedge clk) disable iff (!rst_n)
        (!frameActive && (cmd.op == CRS_OP_ALU || cmd.op == CRS_OP_ADD)) |=>
        flags_reg[0] == $past(cmd.carry)) else $error("alu carry");
    a_set_carry: assert property (@(posedge clk) disable iff (!rst_n)
        (!frameActive && cmd.op == CRS_OP_SETC) |=> flags_reg[0]) else $error("set carry");
    a_clr_carry: assert property (@(posedge clk) disable iff (!rst_n)
        (!frameActive && cmd.op == CRS_OP_CLRC) |=> !flags_reg[0]) else $error("clear carry");
    a_half_carry: assert property (@(posedge clk) disable iff (!rst_n)
        (!frameActive && cmd.op == CRS_OP_ADD) |=> flags_reg[4] == $past(cmd.halfCarry))
        else $error("half carry");

    // scenarios worth seeing at least once
    c_irq_entry: cover property (@(posedge clk) !frameActive && cmd.op == CRS_OP_IRQENTER);
    c_irq_return: cover property (@(posedge clk) !frameActive && cmd.op == CRS_OP_IRQRETURN);
    c_sp_wrap: cover property (@(posedge clk) doPush && spLow_reg == 8'h00);
    c_pop_wrap: cover property (@(posedge clk) doPop && spLow_reg == 8'h7F);
    c_call: cover property (@(posedge clk) !frameActive && cmd.op == CRS_OP_CALL);
endmodule

/* File: crs_consts.svh */
// Purpose: constants for the core register set
// Assumes: included by its bare name
// Notes:   bit positions of the flag register and stack figures
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH
`define CRS_FLAG_CARRY      0
`define CRS_FLAG_ZERO       1
`define CRS_FLAG_NEG        2
`define CRS_FLAG_PRIO_LOW   3
`define CRS_FLAG_HALF       4
`define CRS_FLAG_PRIO_HIGH  5
`define CRS_FLAGS_RESET     8'hE8
`define CRS_SP_RESET        16'h017F
`define CRS_SP_HIGH_BYTE    8'h01
`define CRS_SP_LOW_TOP      8'h7F
`define CRS_SP_LOW_MASK     8'h7F
`define CRS_ACC_RESET       8'h00
`define CRS_PC_RESET        16'h0000
`define CRS_IRQ_FRAME_LEN   3'h5
`endif

/* File: crs_pkg.sv */
// Purpose: types for the core register set
// Assumes: nothing
// Notes:   op codes are driven by the execution unit
package crs_pkg;
    typedef enum logic [3:0] {
        CRS_OP_NONE      = 4'h0,
        CRS_OP_ALU       = 4'h1,
        CRS_OP_ADD       = 4'h2,
        CRS_OP_SETC      = 4'h3,
        CRS_OP_CLRC      = 4'h4,
        CRS_OP_PUSH      = 4'h5,
        CRS_OP_POP       = 4'h6,
        CRS_OP_SPRESET   = 4'h7,
        CRS_OP_SPLOAD    = 4'h8,
        CRS_OP_IRQENTER  = 4'h9,
        CRS_OP_IRQRETURN = 4'hA,
        CRS_OP_PRIOSET   = 4'hB,
        CRS_OP_FLAGWRITE = 4'hC,
        CRS_OP_CALL      = 4'hD
    } crs_op_t;
    typedef enum logic [2:0] {
        CRS_SEL_PCL  = 3'h0,
        CRS_SEL_PCH  = 3'h1,
        CRS_SEL_IDX1 = 3'h2,
        CRS_SEL_ACC  = 3'h3,
        CRS_SEL_FLAG = 3'h4,
        CRS_SEL_IDX2 = 3'h5
    } crs_sel_t;
    typedef struct packed {
        crs_op_t     op;
        crs_sel_t    sel;
        logic [7:0]  data;
        logic [7:0]  result;
        logic        carry;
        logic        halfCarry;
        logic        writeAcc;
        logic [1:0]  prio;
        logic        pcLoad;
        logic [15:0] pcValue;
    } crs_cmd_t;
endpackage

/* File: crs_stack_mem_model.sv */
// Purpose: behavioural stack memory on the far side of the register set
// Assumes: read address and enable come from the bench, one pop a cycle
// Notes:   a released read bus shows the inverse of its last value
`timescale 1ns/10ps
module crs_stack_mem_model (
    input  wire logic        clk,
    input  wire logic [15:0] stackAddr,
    input  wire logic [7:0]  stackWrData,
    input  wire logic        stackWrEn,
    input  wire logic [15:0] rdAddr,
    input  wire logic        rdEn,
    output logic [7:0]       stackRdData
);
    logic [7:0] mem [0:511];
    logic [7:0] lastRdReg = 8'hA5;
    // combinational: the design samples it in the pop cycle itself
    always_comb begin
        stackRdData = rdEn ? mem[rdAddr[8:0]] : ~lastRdReg;
    end
    always_ff @(posedge clk) begin
        if (stackWrEn) begin
            mem[stackAddr[8:0]] <= stackWrData;
        end
    end
    always @(posedge clk) begin
        if (rdEn) begin
            lastRdReg <= stackRdData;
        end
    end
endmodule

/* File: tb_cpu_core_register_set.sv */
// Purpose: self-checking bench for the core register set
// Assumes: integer model of every register, stack memory model on the far side
// Notes:   outputs are read three edges after a command, frames after eight
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin numChecks++; if ((got) !== (ex)) begin errTotal++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_cpu_core_register_set import crs_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, stackWrEn, irqBusy, rdEn = 1'b0;
    crs_cmd_t cmd = '0;
    logic [7:0] stackRdData, accOut, idx1Out, idx2Out, flagsOut, stackWrData;
    logic [15:0] pcOut, stackPtrOut, stackAddr, rdAddr = 16'h0000;
    int mAcc = 0, mIdx1 = 0, mIdx2 = 0, mPc = 0, mFlags = 32'hE8, mSp = 32'h17F;
    int exMem[int];
    int errTotal = 0, numChecks = 0;
    crs_core_register_set dut_u (.clk(clk), .rst_n(rst_n), .cmd(cmd),
        .stackRdData(stackRdData), .accOut(accOut), .idx1Out(idx1Out), .idx2Out(idx2Out),
        .pcOut(pcOut), .flagsOut(flagsOut), .stackPtrOut(stackPtrOut), .stackAddr(stackAddr),
        .stackWrData(stackWrData), .stackWrEn(stackWrEn), .irqBusy(irqBusy));
    crs_stack_mem_model stk_u (.clk(clk), .stackAddr(stackAddr), .stackWrData(stackWrData),
        .stackWrEn(stackWrEn), .rdAddr(rdAddr), .rdEn(rdEn), .stackRdData(stackRdData));
    always #4 clk = ~clk;
    // 128-byte window: only the low seven bits move, so both limits wrap silently
    function int spDec(int s); return 32'h100 | ((s - 1) & 32'h7F); endfunction
    function int spInc(int s); return 32'h100 | ((s + 1) & 32'h7F); endfunction
    function int setBit(int f, int b, bit v); return v ? (f | (1 << b)) : (f & ~(1 << b));
    endfunction
    function crs_cmd_t mk(crs_op_t op, crs_sel_t s, logic [7:0] d);
        mk = '0;
        mk.op = op;
        mk.sel = s;
        mk.data = d;
    endfunction
    function int selVal(crs_sel_t s);
        case (s)
            CRS_SEL_PCL:  return mPc & 32'hFF;
            CRS_SEL_PCH:  return mPc >> 8;
            CRS_SEL_IDX1: return mIdx1;
            CRS_SEL_IDX2: return mIdx2;
            CRS_SEL_FLAG: return mFlags;
            default:      return mAcc;
        endcase
    endfunction
    task setSel(crs_sel_t s, int v);
        case (s)
            CRS_SEL_IDX1: mIdx1 = v;
            CRS_SEL_IDX2: mIdx2 = v;
            CRS_SEL_FLAG: mFlags = v;
            default:      mAcc = v;
        endcase
    endtask
    task step(int n); repeat (n) @(posedge clk); endtask
    task checkAll();
        `CHK("acc", mAcc, accOut)
        `CHK("idx1", mIdx1, idx1Out)
        `CHK("idx2", mIdx2, idx2Out)
        `CHK("pc", mPc, pcOut)
        `CHK("flags", mFlags, flagsOut)
        `CHK("sp", mSp, stackPtrOut)
        `CHK("busy idle", 0, irqBusy)
    endtask
    task checkMem();
        foreach (exMem[a]) `CHK("stack byte", exMem[a], stk_u.mem[a])
    endtask
    task issue(crs_cmd_t c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= '0;
        step(3);
        #1;
        checkAll();
    endtask
    task doPush(crs_sel_t s);
        exMem[mSp] = selVal(s);
        mSp = spDec(mSp);
        issue(mk(CRS_OP_PUSH, s, 8'h00));
    endtask
    task doPop(crs_sel_t s);
        mSp = spInc(mSp);
        setSel(s, exMem[mSp]);
        @(posedge clk);
        cmd <= mk(CRS_OP_POP, s, 8'h00);
        rdEn <= 1'b1;
        rdAddr <= 16'(mSp);
        @(posedge clk);
        cmd <= '0;
        rdEn <= 1'b0;
        step(3);
        #1;
        checkAll();
    endtask
    task doAlu(int i);
        crs_cmd_t c;
        c = '0;
        c.op = ($urandom % 2) ? CRS_OP_ADD : CRS_OP_ALU;
        c.result = (i == 0) ? 8'h00 : 8'($urandom);
        {c.carry, c.halfCarry, c.writeAcc} = 3'($urandom);
        if (c.writeAcc) mAcc = c.result;
        mFlags = setBit(mFlags, 2, c.result[7]);
        mFlags = setBit(mFlags, 1, c.result == 8'h00);
        mFlags = setBit(mFlags, 0, c.carry);
        if (c.op == CRS_OP_ADD) mFlags = setBit(mFlags, 4, c.halfCarry);
        issue(c);
    endtask
    task endTest(string t); $display("test %s done", t); endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #(8 * 5000);
        errTotal++;
        print_verdict();
    end
    initial begin
        crs_cmd_t c;
        int a;
        void'($urandom(65282));
        step(4);
        rst_n <= 1'b1;
        step(2);
        #1;
        checkAll();
        endTest("reset");
        for (int i = 0; i < 40; i++) doAlu(i);
        endTest("alu");
        mFlags = setBit(mFlags, 0, 1);
        issue(mk(CRS_OP_SETC, CRS_SEL_PCL, 8'h00));
        mFlags = setBit(mFlags, 0, 0);
        issue(mk(CRS_OP_CLRC, CRS_SEL_PCL, 8'h00));
        for (int p = 0; p < 4; p++) begin
            c = mk(CRS_OP_PRIOSET, CRS_SEL_PCL, 8'h00);
            c.prio = 2'(p);
            mFlags = setBit(setBit(mFlags, 5, p[1]), 3, p[0]);
            issue(c);
        end
        a = $urandom | 32'hC0;
        mFlags = a & 32'hFE;
        issue(mk(CRS_OP_FLAGWRITE, CRS_SEL_PCL, 8'(mFlags)));
        c = '0;
        c.pcLoad = 1'b1;
        c.pcValue = 16'($urandom);
        mPc = c.pcValue;
        issue(c);
        endTest("flags");
        doPush(CRS_SEL_ACC);
        doAlu(1);
        doPop(CRS_SEL_IDX1);
        doPush(CRS_SEL_ACC);
        doAlu(2);
        doPop(CRS_SEL_IDX2);
        for (int s = 0; s < 6; s++) doPush(crs_sel_t'(s));
        checkMem();
        doPop(CRS_SEL_ACC);
        endTest("push pop");
        a = $urandom;
        mSp = 32'h100 | (a & 32'h7F);
        issue(mk(CRS_OP_SPLOAD, CRS_SEL_PCL, 8'(a)));
        mSp = 32'h100;
        issue(mk(CRS_OP_SPLOAD, CRS_SEL_PCL, 8'h00));
        doPush(CRS_SEL_ACC);
        doPop(CRS_SEL_IDX1);
        mSp = 32'h17F;
        issue(mk(CRS_OP_SPRESET, CRS_SEL_PCL, 8'h00));
        mSp = spDec(spDec(mSp));
        issue(mk(CRS_OP_CALL, CRS_SEL_PCL, 8'h00));
        endTest("stack pointer");
        for (int s = 0; s < 5; s++) begin
            exMem[mSp] = selVal(s == 4 ? CRS_SEL_FLAG : crs_sel_t'(s));
            mSp = spDec(mSp);
        end
        c = mk(CRS_OP_IRQENTER, CRS_SEL_PCL, 8'h00);
        c.prio = 2'b01;
        mFlags = setBit(setBit(mFlags, 5, 0), 3, 1);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= '0;
        @(posedge clk);
        cmd <= mk(CRS_OP_SETC, CRS_SEL_PCL, 8'h00);
        @(posedge clk);
        cmd <= '0;
        #1;
        `CHK("busy frame", 1, irqBusy)
        step(6);
        #1;
        checkAll();
        checkMem();
        doAlu(3);
        c = '0;
        c.pcLoad = 1'b1;
        c.pcValue = 16'h1234;
        mPc = 32'h1234;
        issue(c);
        @(posedge clk);
        cmd <= mk(CRS_OP_IRQRETURN, CRS_SEL_PCL, 8'h00);
        @(posedge clk);
        cmd <= '0;
        rdEn <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            mSp = spInc(mSp);
            rdAddr <= 16'(mSp);
            if (k == 0) mFlags = exMem[mSp];
            if (k == 1) mAcc = exMem[mSp];
            if (k == 2) mIdx1 = exMem[mSp];
            if (k == 3) mPc = (exMem[mSp] << 8) | (mPc & 32'hFF);
            if (k == 4) mPc = (mPc & 32'hFF00) | exMem[mSp];
            @(posedge clk);
        end
        rdEn <= 1'b0;
        step(3);
        #1;
        checkAll();
        endTest("interrupt frame");
        print_verdict();
    end
endmodule
